// ==== ckd_top.sv ====
// APB-controlled integer-N clock output divider with crystal-derived time bases
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module ckd_top #(
	parameter int unsigned AW = 12
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	output logic               clock_output_pin,
	output logic               carrier_clk,
	output logic               mixer_i_clk,
	output logic               mixer_q_clk,
	output logic               coder_strobe
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Feedback select to ratio; the unused code never reaches the config
	function automatic logic [7:0] fb_ratio(input ckd_pkg::ckd_fb_sel_t s);
		case (s)
			ckd_pkg::CKD_FB_27: fb_ratio = ckd_pkg::FB_RATIO_B;
			ckd_pkg::CKD_FB_28: fb_ratio = ckd_pkg::FB_RATIO_C;
			default:            fb_ratio = ckd_pkg::FB_RATIO_A;
		endcase
	endfunction : fb_ratio

	function automatic logic [11:0] word_addr(input logic [AW-1:0] a);
		word_addr = {a[11:2], 2'b00};
	endfunction : word_addr

	ckd_pkg::ckd_cfg_t cfg_r;
	logic              run_r;
	logic [31:0]       inc_out;
	logic [31:0]       thr_out;
	logic              out_tick;
	logic              ref_tick;
	logic [1:0]        quad_r;
	logic [7:0]        coder_cnt_r;
	logic              access;
	logic [11:0]       wa;
	logic              mapped;
	logic [31:0]       rd_nxt;

	assign access = psel & penable;
	assign wa     = word_addr(paddr);
	assign mapped = (wa == ckd_pkg::CTRL_OFS) || (wa == ckd_pkg::DIV_OFS) ||
	                (wa == ckd_pkg::STATUS_OFS);

	// ****************************************************************
	// APB slave: one wait state, write lands at the completing edge
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= access & ~pready;
		end
	end

	// Read data and error flag are loaded together with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr <= ~mapped;
		end else begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
	end

	// Read multiplexer; reserved bits read as zero
	always_comb begin
		rd_nxt = '0;
		case (wa)
			ckd_pkg::CTRL_OFS: begin
				rd_nxt[ckd_pkg::FB_SEL_LSB +: 2] = cfg_r.fb_sel;
				rd_nxt[ckd_pkg::ENABLE_BIT]      = cfg_r.enable;
			end
			ckd_pkg::DIV_OFS: begin
				rd_nxt[ckd_pkg::RATIO_LSB +: 8] = cfg_r.out_ratio;
			end
			ckd_pkg::STATUS_OFS: begin
				rd_nxt[ckd_pkg::ST_RUN_BIT]    = run_r;
				rd_nxt[ckd_pkg::ST_PIN_BIT]    = clock_output_pin;
				rd_nxt[ckd_pkg::ST_FB_LSB +: 8] = fb_ratio(cfg_r.fb_sel);
			end
			default: rd_nxt = '0;
		endcase
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Feedback code 3 is refused so only 23, 27 and 28 can be chosen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r.fb_sel <= ckd_pkg::ckd_fb_sel_t'(ckd_pkg::FB_SEL_RST);
			cfg_r.enable <= ckd_pkg::ENABLE_RST;
		end else if (access && pready && pwrite && wa == ckd_pkg::CTRL_OFS) begin
			if (pwdata[ckd_pkg::FB_SEL_LSB +: 2] != 2'(ckd_pkg::CKD_FB_BAD)) begin
				cfg_r.fb_sel <= ckd_pkg::ckd_fb_sel_t'(pwdata[ckd_pkg::FB_SEL_LSB +: 2]);
			end
			cfg_r.enable <= pwdata[ckd_pkg::ENABLE_BIT];
		end
	end

	// Ratios below the floor are raised to it, capping the pin at 24 MHz
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r.out_ratio <= ckd_pkg::RATIO_RST;
		end else if (access && pready && pwrite && wa == ckd_pkg::DIV_OFS) begin
			if (pwdata[ckd_pkg::RATIO_LSB +: 8] < ckd_pkg::OUT_MIN) begin
				cfg_r.out_ratio <= ckd_pkg::OUT_MIN;
			end else begin
				cfg_r.out_ratio <= pwdata[ckd_pkg::RATIO_LSB +: 8];
			end
		end
	end

	// ****************************************************************
	// Output divider chain
	// ****************************************************************
	// Pin toggles at 2 x fout/scale: fin/2 x FB over OUT, in bus clock steps
	assign inc_out = 32'(ckd_pkg::XTAL_HALF_KHZ) * 32'(fb_ratio(cfg_r.fb_sel));
	assign thr_out = 32'(cfg_r.out_ratio) *
	                 32'(ckd_pkg::MODEL_SCALE * ckd_pkg::PCLK_KHZ / 2);

	ckd_nco #(
		.W(32)
	) u_out_nco (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (~run_r),
		.inc     (inc_out),
		.thr     (thr_out),
		.tick    (out_tick)
	);

	// Gate opens and closes only while the pin is low, so no runt pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= 1'b0;
		end else if (!clock_output_pin) begin
			run_r <= cfg_r.enable;
		end
	end

	// Pin toggles on each divider tick while the gate is open, except a rise once enable drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_output_pin <= 1'b0;
		end else if (!run_r) begin
			clock_output_pin <= 1'b0;
		end else if (out_tick && (clock_output_pin || cfg_r.enable)) begin
			// No fresh rise once enable drops: the gate may close at this same edge
			clock_output_pin <= ~clock_output_pin;
		end
	end

	// ****************************************************************
	// Crystal time bases for carrier, mixer and coder
	// ****************************************************************
	// Free-running; one tick per modelled crystal period
	ckd_nco #(
		.W(32)
	) u_ref_nco (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (1'b0),
		.inc     (32'(ckd_pkg::XTAL_KHZ)),
		.thr     (32'(ckd_pkg::MODEL_SCALE * ckd_pkg::PCLK_KHZ)),
		.tick    (ref_tick)
	);

	// Carrier is crystal over two, i.e. 13.56 MHz scaled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carrier_clk <= 1'b0;
		end else if (ref_tick) begin
			carrier_clk <= ~carrier_clk;
		end
	end

	// Two-bit binary counter, decoded to give I and Q a quarter period apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quad_r      <= 2'h0;
			mixer_i_clk <= 1'b0;
			mixer_q_clk <= 1'b0;
		end else if (ref_tick) begin
			quad_r      <= quad_r + 2'h1;
			mixer_i_clk <= (quad_r + 2'h1) >= 2'h2;
			mixer_q_clk <= ((quad_r + 2'h1) == 2'h1) || ((quad_r + 2'h1) == 2'h2);
		end
	end

	// Coder strobe once per fixed count of crystal ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coder_cnt_r  <= 8'h00;
			coder_strobe <= 1'b0;
		end else if (ref_tick && coder_cnt_r == 8'(ckd_pkg::CODER_DIV - 1)) begin
			coder_cnt_r  <= 8'h00;
			coder_strobe <= 1'b1;
		end else begin
			coder_cnt_r  <= ref_tick ? coder_cnt_r + 8'h01 : coder_cnt_r;
			coder_strobe <= 1'b0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_fb_legal;
		@(posedge pclk) disable iff (!presetn)
		fb_ratio(cfg_r.fb_sel) inside {8'd23, 8'd27, 8'd28} &&
		cfg_r.fb_sel != ckd_pkg::CKD_FB_BAD;
	endproperty
	a_fb_legal: assert property (p_fb_legal)
		else $error("feedback ratio outside 23/27/28");

	property p_ratio_floor;
		@(posedge pclk) disable iff (!presetn)
		cfg_r.out_ratio >= 8'd16;
	endproperty
	a_ratio_floor: assert property (p_ratio_floor)
		else $error("output ratio below 16");

	property p_formula;
		@(posedge pclk) disable iff (!presetn)
		inc_out == 32'h0000_34F8 * 32'(fb_ratio(cfg_r.fb_sel)) &&
		thr_out == 32'h0000_C350 * 32'(cfg_r.out_ratio);
	endproperty
	a_formula: assert property (p_formula)
		else $error("divider increments do not follow the output formula");

	property p_rise_needs_enable;
		@(posedge pclk) disable iff (!presetn)
		$rose(clock_output_pin) |-> $past(run_r) && $past(out_tick) && $past(cfg_r.enable);
	endproperty
	a_rise_needs_enable: assert property (p_rise_needs_enable)
		else $error("pin rose without gate open and divider tick");

	property p_stays_low;
		@(posedge pclk) disable iff (!presetn)
		!cfg_r.enable && !clock_output_pin |=> !clock_output_pin [*3];
	endproperty
	a_stays_low: assert property (p_stays_low)
		else $error("pin left low level while disabled");

	property p_no_runt;
		@(posedge pclk) disable iff (!presetn)
		$fell(clock_output_pin) |-> $past(out_tick) && $past(run_r);
	endproperty
	a_no_runt: assert property (p_no_runt)
		else $error("pin high phase cut short");

	property p_tick_toggles;
		@(posedge pclk) disable iff (!presetn)
		run_r && out_tick && (clock_output_pin || cfg_r.enable) |=>
		clock_output_pin != $past(clock_output_pin);
	endproperty
	a_tick_toggles: assert property (p_tick_toggles)
		else $error("divider tick did not toggle the pin");

	property p_ref_rate;
		@(posedge pclk) disable iff (!presetn)
		ref_tick |=> !ref_tick [*2] ##[1:2] ref_tick;
	endproperty
	a_ref_rate: assert property (p_ref_rate)
		else $error("crystal tick spacing wrong");

	property p_quadrature;
		@(posedge pclk) disable iff (!presetn)
		$changed(mixer_i_clk) |-> $stable(mixer_q_clk);
	endproperty
	a_quadrature: assert property (p_quadrature)
		else $error("I and Q mixer clocks moved together");

	property p_write_lands;
		@(posedge pclk) disable iff (!presetn)
		access && pready && pwrite && wa == ckd_pkg::DIV_OFS &&
		pwdata[7:0] >= 8'd16 |=> cfg_r.out_ratio == $past(pwdata[7:0]);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("output ratio write lost");

	c_enable_run: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(run_r) ##[1:300] $rose(clock_output_pin));
	c_disable_stop: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(cfg_r.enable) ##[1:300] $fell(run_r));
	c_coder: cover property (@(posedge pclk) disable iff (!presetn) coder_strobe);
	c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : ckd_top

// ==== ckd_pkg.sv ====
// Constants, types and register map of the clock output divider block
//
// Overview of operation
// - The crystal reference of 27.12 MHz is the only source of the integer-N loop.
// - The clock output pin can run anywhere between about 1.22 MHz and 24 MHz by divider choice.
// - The feedback divider offers only the ratios 23, 27 and 28; the VCO runs at ratio x fin/2.
// - The VCO frequency is divided by the programmed output ratio to give the output clock.
// - The divided clock reaches the clock output pin while clock_out_enable is set; a high phase in progress when it clears runs to its end.
// - The output frequency is 13.56 MHz times feedback_ratio divided by output_ratio.
// - Carrier timing, I and Q mixer clocks and coder strobes are derived from the crystal.
package ckd_pkg;

	// ****************************************************************
	// Clock figures
	// ****************************************************************
	localparam int unsigned PCLK_KHZ      = 25000;   // Bus clock, 40 ns period
	localparam int unsigned XTAL_KHZ      = 27120;   // Crystal reference
	localparam int unsigned XTAL_HALF_KHZ = XTAL_KHZ / 2; // fin/2 = 13.56 MHz
	localparam int unsigned MODEL_SCALE   = 4;       // Modelled clocks run this much slower
	localparam int unsigned CODER_DIV     = 128;     // Crystal ticks per coder strobe

	// ****************************************************************
	// Register map (byte addresses) and fields
	// ****************************************************************
	localparam logic [11:0] CTRL_OFS    = 12'h000;
	localparam logic [11:0] DIV_OFS     = 12'h004;
	localparam logic [11:0] STATUS_OFS  = 12'h008;
	localparam int unsigned FB_SEL_LSB  = 0;         // CTRL[1:0] feedback select
	localparam int unsigned ENABLE_BIT  = 8;         // CTRL[8] clock_out_enable
	localparam int unsigned RATIO_LSB   = 0;         // DIV[7:0] output_ratio
	localparam int unsigned ST_RUN_BIT  = 0;         // STATUS[0] pin gate open
	localparam int unsigned ST_PIN_BIT  = 1;         // STATUS[1] pin level
	localparam int unsigned ST_FB_LSB   = 8;         // STATUS[15:8] active feedback ratio

	// ****************************************************************
	// Ratios and reset values
	// ****************************************************************
	localparam logic [7:0] FB_RATIO_A   = 8'h17;     // 23
	localparam logic [7:0] FB_RATIO_B   = 8'h1B;     // 27
	localparam logic [7:0] FB_RATIO_C   = 8'h1C;     // 28
	localparam logic [7:0] OUT_MIN      = 8'h10;     // 16 keeps the pin at or below 24 MHz
	localparam logic [1:0] FB_SEL_RST   = 2'h0;
	localparam logic [7:0] RATIO_RST    = 8'h4E;     // 78, gives 4 MHz with ratio 23
	localparam logic       ENABLE_RST   = 1'b0;

	typedef enum logic [1:0] {CKD_FB_23, CKD_FB_27, CKD_FB_28, CKD_FB_BAD} ckd_fb_sel_t;

	// Software settings that steer the divider chain
	typedef struct packed {
		ckd_fb_sel_t fb_sel;
		logic [7:0]  out_ratio;
		logic        enable;
	} ckd_cfg_t;

endpackage : ckd_pkg

// ==== ckd_nco.sv ====
// Phase accumulator that emits one tick per programmed fraction of the bus clock
`timescale 1ns/1ps
module ckd_nco #(
	parameter int unsigned W = 32
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         restart,
	input  wire logic [W-1:0] inc,
	input  wire logic [W-1:0] thr,
	output logic              tick
);

	logic [W-1:0] acc_r;
	logic [W:0]   sum;

	assign sum = {1'b0, acc_r} + {1'b0, inc};

	// ****************************************************************
	// Accumulate; wrap at the threshold and pulse the tick
	// ****************************************************************
	// Restart zeroes the phase so the first period after it is a full one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= '0;
			tick  <= 1'b0;
		end else if (restart) begin
			acc_r <= '0;
			tick  <= 1'b0;
		end else if (sum >= {1'b0, thr}) begin
			acc_r <= W'(sum - {1'b0, thr});
			tick  <= 1'b1;
		end else begin
			acc_r <= sum[W-1:0];
			tick  <= 1'b0;
		end
	end

endmodule : ckd_nco

// ==== ckd_mcu_model.sv ====
// Model of the microcontroller that takes its clock from the divided pin
`timescale 1ns/1ps
module ckd_mcu_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clear,
	input  wire logic        clk_in,
	output logic [31:0]      rises
);
	logic        prev_r;
	logic [31:0] rises_r;

	// ****************************************************************
	// Clock edge tally
	// ****************************************************************
	// Sampled on the bus clock: every modelled clock is a bus-clock register,
	// so a runt high pulse still shows up as one extra rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r  <= 1'b0;
			rises_r <= 32'h0;
		end else begin
			prev_r <= clk_in;
			if (clear)
				rises_r <= 32'h0;
			else if (clk_in && !prev_r)
				rises_r <= rises_r + 32'h1;
		end
	end

	assign rises = rises_r;
endmodule : ckd_mcu_model

// ==== ckd_top_tb_top.sv ====
// Self-checking bench for the clock output divider and its time bases
`timescale 1ns/1ps
module ckd_top_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clr;
	logic        clock_output_pin, carrier_clk, mixer_i_clk, mixer_q_clk, coder_strobe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, n_pin, n_car, n_mi, n_mq, n_cod;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          fb_t[9] = '{23, 27, 23, 28, 23, 28, 23, 28, 28};
	int          out_t[9] = '{78, 61, 39, 38, 26, 19, 16, 206, 103};
	int          fbv[3] = '{23, 27, 28};

	// ****************************************************************
	// Device and far-side counters
	// ****************************************************************
	ckd_top uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clock_output_pin(clock_output_pin), .carrier_clk(carrier_clk),
		.mixer_i_clk(mixer_i_clk), .mixer_q_clk(mixer_q_clk), .coder_strobe(coder_strobe)
	);
	ckd_mcu_model m_pin (.pclk(pclk), .presetn(presetn), .clear(clr),
		.clk_in(clock_output_pin), .rises(n_pin));
	ckd_mcu_model m_car (.pclk(pclk), .presetn(presetn), .clear(clr),
		.clk_in(carrier_clk), .rises(n_car));
	ckd_mcu_model m_mi (.pclk(pclk), .presetn(presetn), .clear(clr),
		.clk_in(mixer_i_clk), .rises(n_mi));
	ckd_mcu_model m_mq (.pclk(pclk), .presetn(presetn), .clear(clr),
		.clk_in(mixer_q_clk), .rises(n_mq));
	ckd_mcu_model m_cod (.pclk(pclk), .presetn(presetn), .clear(clr),
		.clk_in(coder_strobe), .rises(n_cod));

	// Bus clock, 40 ns period
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Hang guard, well above the roughly 52000 cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			n_fail++;
			summarize();
		end
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task summarize;
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_fail++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk_rng

	// One APB transfer; waits for pready without assuming the wait count
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ends once pready is seen high; only the bench timeout ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		// Ready stands for one cycle only
		chk("pready drop", 32'h0, {31'h0, pready});
	endtask : apb

	// Clears every edge tally, then lets n cycles pass
	task window(input int n);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask : window

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_reset;
		apb(1'b0, ckd_pkg::CTRL_OFS, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, ckd_pkg::DIV_OFS, 32'h0);
		chk("div reset", 32'h4E, rd);
		apb(1'b0, ckd_pkg::STATUS_OFS, 32'h0);
		chk("status reset", 32'h1700, rd);
		chk("pin reset", 32'h0, {31'h0, clock_output_pin});
	endtask : t_reset

	task t_regs;
		apb(1'b1, ckd_pkg::DIV_OFS, 32'h5);
		apb(1'b0, ckd_pkg::DIV_OFS, 32'h0);
		chk("div floor", 32'h10, rd);
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, ckd_pkg::CTRL_OFS, 32'(s));
			apb(1'b0, ckd_pkg::STATUS_OFS, 32'h0);
			chk("fb ratio", 32'(fbv[s]), {24'h0, rd[15:8]});
		end
		// Code 3 has no ratio behind it, so the last legal choice must stay
		apb(1'b1, ckd_pkg::CTRL_OFS, 32'h3);
		apb(1'b1, ckd_pkg::STATUS_OFS, 32'hFFFFFFFF);
		chk("status write err", 32'h0, {31'h0, err});
		apb(1'b0, ckd_pkg::STATUS_OFS, 32'h0);
		chk("fb refused", 32'h1C00, rd);
		apb(1'b0, ckd_pkg::CTRL_OFS, 32'h0);
		chk("ctrl refused", 32'h2, rd);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
	endtask : t_regs

	task t_freq;
		int e;
		int s;
		for (int i = 0; i < 9; i++) begin
			s = (fb_t[i] == 23) ? 0 : ((fb_t[i] == 27) ? 1 : 2);
			apb(1'b1, ckd_pkg::DIV_OFS, 32'(out_t[i]));
			apb(1'b1, ckd_pkg::CTRL_OFS, 32'h100 | 32'(s));
			apb(1'b0, ckd_pkg::STATUS_OFS, 32'h0);
			chk("gate open", 32'h1, {31'h0, rd[0]});
			window(5000);
			// 13.56 MHz * FB / OUT at quarter model speed over 5000 bus cycles
			e = 678 * fb_t[i] / out_t[i];
			chk_rng("pin rises", e - 2, e + 3, n_pin);
		end
	endtask : t_freq

	task t_xtal;
		window(5000);
		chk_rng("carrier rises", 675, 681, n_car);
		chk_rng("mixer i rises", 336, 342, n_mi);
		chk_rng("mixer q rises", 336, 342, n_mq);
		chk_rng("coder strobes", 9, 12, n_cod);
	endtask : t_xtal

	task t_off;
		apb(1'b1, ckd_pkg::CTRL_OFS, 32'h2);
		repeat (100) @(posedge pclk);
		window(1000);
		chk_rng("pin rises off", 0, 0, n_pin);
		chk("pin off", 32'h0, {31'h0, clock_output_pin});
		apb(1'b0, ckd_pkg::STATUS_OFS, 32'h0);
		chk("status off", 32'h1C00, rd);
	endtask : t_off

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		clr = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_regs();
		t_freq();
		t_xtal();
		t_off();
		summarize();
	end
endmodule : ckd_top_tb_top
